// [common/chp_pkg.sv]
// Purpose: shared constants and types for the card host port signal control
// Assumes: 50 MHz clk, host pins asynchronous to it
// Notes: pin bundle order fixes the synchroniser vector layout
`default_nettype none
package chp_pkg;
  localparam int DATA_W = 16;
  localparam int ADDR_W = 11;
  localparam int CLK_PERIOD_NS = 20;
  // Initialisation time after reset, ready held low meanwhile
  localparam int INIT_TIME_NS = 2000;
  localparam int INIT_CYCLES = (INIT_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // Length of a pulse-mode interrupt
  localparam int IRQ_PULSE_NS = 200;
  localparam int IRQ_PULSE_CYCLES = IRQ_PULSE_NS / CLK_PERIOD_NS;
  localparam int CNT_W = 8;

  typedef enum logic [1:0] {MODE_MEM, MODE_IO, MODE_DISK} chp_mode_t;
  typedef enum logic [2:0] {
    TGT_COMMON, TGT_ATTR, TGT_IO, TGT_TASKFILE, TGT_ALTCTL, TGT_DMA
  } chp_target_t;

  typedef struct packed {
    logic unit_select_strap;
    logic disk_mode_select_n;
    logic card_reset;
    logic space_select_n;
    logic io_write_strobe_n;
    logic output_enable_n;
    logic [1:0] disk_chip_selects_n;
    logic dma_ack_n;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } chp_pins_t;

  typedef struct packed {
    chp_target_t target;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } chp_access_t;
endpackage : chp_pkg
`default_nettype wire

// [logic/chp_signal_ctrl.sv]
// Purpose: card-side handling of host strobes, selects, ready, interrupt, DMA
// Assumes: host pins asynchronous; core supplies busy, read data and events
// Notes: memory vs I/O card mode comes from the core's configuration
// What this block does
// - Strap grounded primary, open secondary
// - I/O write rising edge latches data
// - Memory mode: output enable drives data
// - I/O mode: output enable reads attribute only
// - Memory mode ready low busy, high free
// - Ready low during initialisation; host waits
// - Reset held since power-up keeps ready high
// - I/O interrupt active low, pulse or level
// - Disk interrupt is active high
// - Space select routes common or attribute
// - DMA request answered by active-low acknowledge
// - DMA disabled: acknowledge ignored
// - Card modes: reset active high
// - Disk mode: reset active low
// - Chip selects: task file, alternate; DMA words
`default_nettype none
module chp_signal_ctrl
  import chp_pkg::*;
#(
  parameter int INIT_CNT = INIT_CYCLES,
  parameter int PULSE_CNT = IRQ_PULSE_CYCLES
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic clk_en,
  input wire chp_pins_t pins,
  output logic [DATA_W-1:0] data_out,
  output logic data_oe_n,
  output logic ready,
  output logic io_irq_n,
  output logic disk_irq,
  output logic dma_request,
  output logic unit_secondary,
  output logic card_in_reset,
  output chp_mode_t mode,
  input wire logic io_mode_cfg,
  input wire logic core_busy,
  input wire logic core_irq,
  input wire logic irq_level_mode,
  input wire logic irq_service,
  input wire logic dma_enable,
  input wire logic core_dma_req,
  input wire logic [DATA_W-1:0] rd_data,
  output logic rd_active,
  output chp_access_t rd_acc,
  output logic wr_valid,
  output chp_access_t wr_acc
);
  localparam int PW = $bits(chp_pins_t);
  if (INIT_CNT < 1 || INIT_CNT >= 2**CNT_W ||
      PULSE_CNT < 1 || PULSE_CNT >= 2**CNT_W) begin : g_bad_count
    $error("count parameter out of range");
  end
  // ************************************************************
  // Pin synchroniser
  // ************************************************************
  logic [PW-1:0] s1_r, s2_r, s3_r, stab_r, stab_nxt;
  chp_pins_t stab, stab_q;
  always_comb begin
    stab_nxt = (~(s2_r ^ s3_r) & s3_r) | ((s2_r ^ s3_r) & stab_r);
  end
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      s1_r <= '1;
      s2_r <= '1;
      s3_r <= '1;
      stab_r <= '1;
    end else if (clk_en) begin
      s1_r <= pins;
      s2_r <= s1_r;
      s3_r <= s2_r;
      stab_r <= stab_nxt;
    end
  end
  assign stab = chp_pins_t'(stab_r);
  assign stab_q = chp_pins_t'(stab_nxt);
  // ************************************************************
  // Mode and reset decode
  // ************************************************************
  typedef enum logic [1:0] {ST_HELD, ST_INIT, ST_RUN} chp_state_t;
  chp_state_t st_r, st_nxt;
  logic pin_rst, cont_r, cont_nxt, ready_r, ready_nxt;
  logic [CNT_W-1:0] init_r, init_nxt;
  // mode select low means disk interface
  always_comb begin
    if (!stab.disk_mode_select_n) begin
      mode = MODE_DISK;
    end else if (io_mode_cfg) begin
      mode = MODE_IO;
    end else begin
      mode = MODE_MEM;
    end
  end
  assign pin_rst = (mode == MODE_DISK) ? !stab.card_reset : stab.card_reset;
  always_comb begin
    st_nxt = st_r;
    cont_nxt = cont_r;
    init_nxt = init_r;
    case (st_r)
      ST_HELD: begin
        if (!pin_rst) begin
          st_nxt = ST_INIT;
          init_nxt = CNT_W'(INIT_CNT - 1);
        end
      end
      ST_INIT: begin
        if (pin_rst) begin
          st_nxt = ST_HELD;
          cont_nxt = 1'b0;
        end else if (init_r == '0) begin
          st_nxt = ST_RUN;
        end else begin
          init_nxt = init_r - 1'b1;
        end
      end
      default: begin
        if (pin_rst) begin
          st_nxt = ST_HELD;
          cont_nxt = 1'b0;
        end
      end
    endcase
    // reset held since power-up: ready high
    case (st_nxt)
      ST_HELD: ready_nxt = cont_nxt;
      ST_INIT: ready_nxt = 1'b0;
      default: ready_nxt = !core_busy;
    endcase
  end
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      st_r <= ST_HELD;
      cont_r <= 1'b1;
      init_r <= '0;
      ready_r <= 1'b1;
    end else if (clk_en) begin
      st_r <= st_nxt;
      cont_r <= cont_nxt;
      init_r <= init_nxt;
      ready_r <= ready_nxt;
    end
  end
  assign ready = ready_r;
  assign card_in_reset = (st_r != ST_RUN);
  assign unit_secondary = stab.unit_select_strap;
  // ************************************************************
  // Host access decode
  // ************************************************************
  logic wr_rise, dma_on, oe_act;
  chp_access_t acc;
  logic wr_v_r, wr_v_nxt, oe_n_r, oe_n_nxt;
  chp_access_t wr_acc_r, wr_acc_nxt;
  logic [DATA_W-1:0] dout_r, dout_nxt;
  assign wr_rise = !stab.io_write_strobe_n && stab_q.io_write_strobe_n;
  assign dma_on = dma_enable && !stab.dma_ack_n && (mode == MODE_DISK);
  assign oe_act = !stab.output_enable_n && (st_r == ST_RUN);
  always_comb begin
    acc.addr = stab.addr;
    acc.data = stab.data;
    acc.target = TGT_IO;
    // space select picks common or attribute
    if (mode == MODE_MEM) begin
      acc.target = stab.space_select_n ? TGT_COMMON : TGT_ATTR;
    // DMA words, else chip select picks bank
    end else if (mode == MODE_DISK) begin
      if (dma_on) begin
        acc.target = TGT_DMA;
      end else if (!stab.disk_chip_selects_n[0]) begin
        acc.target = TGT_TASKFILE;
      end else begin
        acc.target = TGT_ALTCTL;
      end
    end
  end
  always_comb begin
    wr_acc_nxt = wr_acc_r;
    // rising edge writes in I/O and disk modes
    wr_v_nxt = wr_rise && (mode != MODE_MEM) && (st_r == ST_RUN);
    if (wr_v_nxt) begin
      wr_acc_nxt = acc;
    end
    // memory mode read while strobe held
    // I/O mode read limited to attribute space
    oe_n_nxt = !(oe_act && (mode == MODE_MEM || (mode == MODE_IO && !stab.space_select_n)));
    dout_nxt = oe_n_nxt ? dout_r : rd_data;
  end
  assign rd_active = oe_act && (mode != MODE_DISK);
  always_comb begin
    rd_acc = acc;
    if (mode == MODE_IO) begin
      rd_acc.target = TGT_ATTR;
    end
  end
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      wr_v_r <= 1'b0;
      wr_acc_r <= '0;
      oe_n_r <= 1'b1;
      dout_r <= '0;
    end else if (clk_en) begin
      wr_v_r <= wr_v_nxt;
      wr_acc_r <= wr_acc_nxt;
      oe_n_r <= oe_n_nxt;
      dout_r <= dout_nxt;
    end
  end
  assign wr_valid = wr_v_r;
  assign wr_acc = wr_acc_r;
  assign data_oe_n = oe_n_r;
  assign data_out = dout_r;
  // ************************************************************
  // Interrupt and DMA request
  // ************************************************************
  logic pend_r, pend_nxt, dreq_r, dreq_nxt;
  logic [CNT_W-1:0] pulse_r, pulse_nxt;
  always_comb begin
    // Set wins over a same-cycle service
    pend_nxt = core_irq || (pend_r && !irq_service);
    pulse_nxt = pulse_r;
    if (core_irq && !irq_level_mode) begin
      pulse_nxt = CNT_W'(PULSE_CNT);
    end else if (pulse_r != '0) begin
      pulse_nxt = pulse_r - 1'b1;
    end
    // request only in disk mode with DMA on
    dreq_nxt = core_dma_req && dma_enable && (mode == MODE_DISK);
  end
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      pend_r <= 1'b0;
      pulse_r <= '0;
      dreq_r <= 1'b0;
    end else if (clk_en) begin
      pend_r <= pend_nxt;
      pulse_r <= pulse_nxt;
      dreq_r <= dreq_nxt;
    end
  end
  assign io_irq_n = !((mode == MODE_IO) && (irq_level_mode ? pend_r : (pulse_r != '0)));
  assign disk_irq = (mode == MODE_DISK) && pend_r;
  assign dma_request = dreq_r;
  // ************************************************************
  // Assertions
  // ************************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  property p_wr_latch; clk_en && wr_rise && mode != MODE_MEM && st_r == ST_RUN |=>
    wr_valid && wr_acc.data == $past(stab.data); endproperty
  a_wr_latch: assert property (p_wr_latch) else $error("write not latched");
  property p_mem_read; clk_en && oe_act && mode == MODE_MEM |=> !data_oe_n; endproperty
  a_mem_read: assert property (p_mem_read) else $error("memory read not driven");
  property p_io_read; clk_en && oe_act && mode == MODE_IO && stab.space_select_n |=>
    data_oe_n; endproperty
  a_io_read: assert property (p_io_read) else $error("I/O read outside attribute");
  property p_busy; clk_en && st_r == ST_RUN && !pin_rst && core_busy |=> !ready; endproperty
  a_busy: assert property (p_busy) else $error("ready high while busy");
  property p_init; st_r == ST_INIT |-> !ready; endproperty
  a_init: assert property (p_init) else $error("ready high in init");
  property p_held; st_r == ST_HELD && cont_r |-> ready; endproperty
  a_held: assert property (p_held) else $error("ready low under held reset");
  property p_pulse; clk_en && core_irq && !irq_level_mode && mode == MODE_IO ##1
    mode == MODE_IO |-> !io_irq_n; endproperty
  a_pulse: assert property (p_pulse) else $error("no interrupt pulse");
  property p_disk_irq; clk_en && core_irq && mode == MODE_DISK ##1 mode == MODE_DISK
    |-> disk_irq; endproperty
  a_disk_irq: assert property (p_disk_irq) else $error("disk interrupt missing");
  property p_dma_off; clk_en && !dma_enable && wr_v_nxt
    |=> wr_acc.target != TGT_DMA; endproperty
  a_dma_off: assert property (p_dma_off) else $error("acknowledge used while off");
  property p_disk_rst; clk_en && mode == MODE_DISK && !stab.card_reset
    |=> st_r == ST_HELD; endproperty
  a_disk_rst: assert property (p_disk_rst) else $error("low reset not taken");
  c_write: cover property (wr_valid && wr_acc.target == TGT_TASKFILE);
  c_dma: cover property (dma_request ##[1:20] wr_valid && wr_acc.target == TGT_DMA);
  c_init_done: cover property (st_r == ST_INIT ##1 st_r == ST_RUN);
endmodule : chp_signal_ctrl
`default_nettype wire

// [tb/chp_host_model.sv]
// Purpose: host socket model driving the raw card pins
// Assumes: pins change 1 ns after a clk edge
// Notes: bus released to inverse of last word
`default_nettype none
module chp_host_model
  import chp_pkg::*;
(
  input wire logic clk,
  output var chp_pins_t p
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    p = '1;
    p.addr = '0;
    p.data = '0;
  end
  task automatic wait_n(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic io_write(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    p.addr = a;
    p.data = d;
    p.io_write_strobe_n = 1'b0;
    wait_n(5);
    p.io_write_strobe_n = 1'b1;
    wait_n(8);
    p.data = ~d;
  endtask
  task automatic oe(input logic sp, input logic v);
    p.space_select_n = sp;
    p.output_enable_n = v;
    wait_n(7);
  endtask
endmodule // chp_host_model
`default_nettype wire

// [tb/tb_card_host_port_signal_control.sv]
// Purpose: self-checking bench for chp_signal_ctrl
// Assumes: INIT_CNT 3, PULSE_CNT 2 to keep the run short
// Notes: syncing latency absorbed by bounded waits
`default_nettype none
module tb_card_host_port_signal_control
  import chp_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int IC = 3;
  localparam int PC = 2;
  logic clk, sys_rst, clk_en;
  logic core_busy, core_irq, irq_level_mode, irq_service;
  logic dma_enable, core_dma_req, io_mode_cfg;
  logic [DATA_W-1:0] rd_data, data_out;
  logic data_oe_n, ready, io_irq_n, disk_irq, dma_request, unit_secondary;
  logic card_in_reset, rd_active, wr_valid;
  chp_mode_t mode;
  chp_access_t rd_acc, wr_acc, last_wr;
  chp_pins_t pins;
  int n_mismatch = 0, check_count = 0, n_wr = 0, cyc = 0;
  always #10 clk = ~clk;
  chp_host_model host (.clk(clk), .p(pins));
  chp_signal_ctrl #(.INIT_CNT(IC), .PULSE_CNT(PC)) DUT (.clk(clk), .sys_rst(sys_rst),
    .clk_en(clk_en), .pins(pins), .data_out(data_out), .data_oe_n(data_oe_n),
    .ready(ready), .io_irq_n(io_irq_n), .disk_irq(disk_irq), .dma_request(dma_request),
    .unit_secondary(unit_secondary), .card_in_reset(card_in_reset), .mode(mode),
    .io_mode_cfg(io_mode_cfg), .core_busy(core_busy), .core_irq(core_irq),
    .irq_level_mode(irq_level_mode), .irq_service(irq_service), .dma_enable(dma_enable),
    .core_dma_req(core_dma_req), .rd_data(rd_data), .rd_active(rd_active),
    .rd_acc(rd_acc), .wr_valid(wr_valid), .wr_acc(wr_acc));
  always @(posedge clk) begin
    cyc++;
    if (wr_valid === 1'b1) begin
      n_wr++;
      last_wr = wr_acc;
    end
    // Hang guard well above the few hundred cycles used
    if (cyc == 4000) begin
      n_mismatch++;
      stop_test();
    end
  end
  task automatic stop_test();
    if (n_mismatch == 0 && check_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task automatic chk(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
    check_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic pulse(ref logic s);
    s = 1'b1;
    host.wait_n(1);
    s = 1'b0;
  endtask
  task automatic t_power();
    int k;
    host.wait_n(10);
    chk(ready, 1);
    chk(card_in_reset, 1);
    host.p.card_reset = 1'b0;
    for (k = 0; k < 12 && ready !== 1'b0; k++) host.wait_n(1);
    chk(ready, 0);
    for (k = 0; k < 20 && card_in_reset === 1'b1; k++) host.wait_n(1);
    chk(k >= IC && k <= IC + 2, 1);
    host.wait_n(1);
    chk(ready, 1);
    // Clock enable low freezes ready
    clk_en = 1'b0;
    core_busy = 1'b1;
    host.wait_n(3);
    chk(ready, 1);
    clk_en = 1'b1;
    host.wait_n(2);
    chk(ready, 0);
    core_busy = 1'b0;
    host.wait_n(2);
    chk(ready, 1);
  endtask
  task automatic t_write();
    io_mode_cfg = 1'b1;
    host.p.space_select_n = 1'b0;
    host.io_write(11'h123, 16'hBEEF);
    host.io_write(11'h7FF, 16'h0000);
    chk(n_wr, 2);
    chk(last_wr.addr, 11'h7FF);
    chk(last_wr.data, 16'h0000);
    chk(last_wr.target, TGT_IO);
    io_mode_cfg = 1'b0;
    host.io_write(11'h001, 16'h1234);
    chk(n_wr, 2);
  endtask
  task automatic t_read();
    host.oe(1'b1, 1'b0);
    chk(data_oe_n, 0);
    chk(data_out, 16'hA5C3);
    // Data follows the core word while the strobe stays low
    rd_data = 16'h1E2D;
    host.wait_n(2);
    chk(data_out, 16'h1E2D);
    chk(rd_acc.target, TGT_COMMON);
    host.oe(1'b0, 1'b0);
    chk(rd_acc.target, TGT_ATTR);
    host.oe(1'b1, 1'b1);
    chk(data_oe_n, 1);
    io_mode_cfg = 1'b1;
    host.oe(1'b1, 1'b0);
    chk(data_oe_n, 1);
    host.oe(1'b0, 1'b0);
    chk(data_oe_n, 0);
    chk(rd_acc.target, TGT_ATTR);
    host.oe(1'b1, 1'b1);
  endtask
  task automatic t_irq();
    pulse(core_irq);
    chk(io_irq_n, 0);
    host.wait_n(PC + 2);
    chk(io_irq_n, 1);
    // Pulse mode leaves the event pending: clear it first
    pulse(irq_service);
    irq_level_mode = 1'b1;
    host.wait_n(1);
    chk(io_irq_n, 1);
    pulse(core_irq);
    host.wait_n(6);
    chk(io_irq_n, 0);
    pulse(irq_service);
    host.wait_n(1);
    chk(io_irq_n, 1);
    // Event and service in one cycle: event wins
    core_irq = 1'b1;
    pulse(irq_service);
    core_irq = 1'b0;
    host.wait_n(1);
    chk(io_irq_n, 0);
    pulse(irq_service);
  endtask
  task automatic t_disk();
    // Reset pin is active low in disk mode: release it as the mode switches
    host.p.card_reset = 1'b1;
    host.p.disk_mode_select_n = 1'b0;
    host.p.disk_chip_selects_n = 2'b10;
    host.wait_n(15);
    chk(mode, MODE_DISK);
    chk(card_in_reset, 0);
    pulse(core_irq);
    host.wait_n(1);
    chk(disk_irq, 1);
    chk(io_irq_n, 1);
    pulse(irq_service);
    dma_enable = 1'b1;
    core_dma_req = 1'b1;
    host.wait_n(2);
    chk(dma_request, 1);
    host.p.dma_ack_n = 1'b0;
    host.io_write(11'h010, 16'h5A5A);
    chk(last_wr.target, TGT_DMA);
    dma_enable = 1'b0;
    core_dma_req = 1'b0;
    host.io_write(11'h011, 16'hC3C3);
    chk(last_wr.target, TGT_TASKFILE);
    host.p.dma_ack_n = 1'b1;
    host.p.disk_chip_selects_n = 2'b01;
    host.io_write(11'h016, 16'h0F0F);
    chk(last_wr.target, TGT_ALTCTL);
    host.p.card_reset = 1'b0;
    host.wait_n(6);
    chk(card_in_reset, 1);
    host.p.card_reset = 1'b1;
  endtask
  task automatic t_strap();
    host.p.unit_select_strap = 1'b0;
    host.wait_n(6);
    chk(unit_secondary, 0);
    host.p.unit_select_strap = 1'b1;
    host.wait_n(6);
    chk(unit_secondary, 1);
  endtask
  task automatic t_rerun();
    // Second reset in disk mode: outputs idle, then running again
    sys_rst = 1'b1;
    host.wait_n(2);
    chk(ready, 1);
    chk(card_in_reset, 1);
    chk(data_oe_n, 1);
    chk(dma_request, 0);
    sys_rst = 1'b0;
    host.wait_n(12);
    chk(mode, MODE_DISK);
    chk(card_in_reset, 0);
    chk(ready, 1);
  endtask
  initial begin
    clk = 1'b0;
    sys_rst = 1'b1;
    clk_en = 1'b1;
    core_busy = 1'b0;
    core_irq = 1'b0;
    irq_level_mode = 1'b0;
    irq_service = 1'b0;
    dma_enable = 1'b0;
    core_dma_req = 1'b0;
    io_mode_cfg = 1'b0;
    rd_data = 16'hA5C3;
    host.wait_n(3);
    sys_rst = 1'b0;
    t_power();
    t_write();
    t_read();
    t_irq();
    t_strap();
    t_disk();
    t_rerun();
    stop_test();
  end
endmodule // tb_card_host_port_signal_control
`default_nettype wire
